// ---- flow_pkg.sv ----
/*
  shared constants, register map and field layouts for the modem-status,
  scratch and extra-control logic of a small uart.
  assumes a 32-bit ahb-lite bus with word-aligned registers.
*/
package flow_pkg;

	// register byte offsets
	localparam logic [7:0] modem_control_off = 8'h00;
	localparam logic [7:0] modem_status_off = 8'h04;
	localparam logic [7:0] scratch_byte_off = 8'h08;
	localparam logic [7:0] extra_control_off = 8'h0c;
	localparam logic [7:0] flow_status_off = 8'h10;

	// field positions
	localparam int mcr_rts_bit = 1;
	localparam int msr_cts_bit = 4;
	localparam int fst_cts_line_bit = 0;
	localparam int fst_rts_line_bit = 1;
	localparam int fst_tx_idle_bit = 2;
	localparam int fst_rx_idle_bit = 3;

	// receive fifo depth and thresholds (free slots)
	localparam int rx_depth = 8;
	localparam logic [3:0] thr_code0 = 4'h3;
	localparam logic [3:0] thr_code1 = 4'h2;
	localparam logic [3:0] thr_code2 = 4'h1;
	localparam logic [3:0] thr_code3 = 4'h4;

	// reset values
	localparam logic [7:0] scratch_rst = 8'h00;
	localparam logic mcr_rts_rst = 1'h0;
	localparam logic cts_level_rst = 1'h0;

	// extra control register, bits 7..0
	typedef struct packed {
		logic cts_low_assert;
		logic rts_low_assert;
		logic [1:0] rts_level;
		logic tx_auto_flow;
		logic rx_auto_flow;
		logic tx_enable;
		logic rx_enable;
	} extra_control_s;

	localparam extra_control_s extra_control_rst = 8'h03;

	// bus request captured in the address phase
	typedef struct packed {
		logic write;
		logic [7:0] addr;
	} bus_req_s;

	typedef enum logic [1:0] {bus_idle, bus_write, bus_fetch, bus_read} bus_state_e;

endpackage

// ---- pin_sync.sv ----
/*
  three-flop input synchroniser with agreement filter.
  assumes the input is asynchronous to clk_i; output level changes only once
  the second and third stages agree.
*/
module pin_sync #(
	parameter logic rst_val = 1'h0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// pin and filtered level
	input wire logic pin_i,
	output logic level_o
);

	logic s1_reg, s2_reg, s3_reg, level_reg;
	logic level_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		level_next = level_reg;
		if (s2_reg == s3_reg) begin
			level_next = s3_reg;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_reg <= rst_val;
			s2_reg <= rst_val;
			s3_reg <= rst_val;
			level_reg <= rst_val;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level_o = level_reg;

endmodule

// ---- symbol_gate.sv ----
/*
  start gate for one direction of the uart (transmit or receive).
  assumes the shifter raises req_i while it wants to begin a symbol and
  pulses done_i at the end of that symbol. permission is checked only when
  a symbol starts, so one in flight always finishes.
*/
module symbol_gate (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// permission from the control logic
	input wire logic allow_i,
	// shifter side
	input wire logic req_i,
	input wire logic done_i,
	output logic start_o,
	output logic idle_o
);

	logic active_reg, active_next;
	logic start;

	////////////////////////////////////////////////////////////////////////
	// a refused start stays pending in the shifter; nothing is dropped here
	assign start = req_i && allow_i && !active_reg;

	always_comb begin
		active_next = active_reg;
		if (start) begin
			active_next = 1'b1;
		end else if (done_i) begin
			active_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
		end
	end

	assign start_o = start;
	assign idle_o = !active_reg;

endmodule

// ---- uart_modem_flow.sv ----
/*
  modem-status, scratch, extra-control and hardware flow control of a uart,
  with an ahb-lite slave for the registers.
  assumes the transmit and receive shifters and the receive fifo sit on the
  same clock; only the clear-to-send pin is asynchronous.

*/
module uart_modem_flow
	import flow_pkg::*;
#(
	parameter int rx_fifo_depth = rx_depth
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// handshake pins
	input wire logic clear_to_send_pin_i,
	output logic request_to_send_pin_o,
	// transmit shifter
	input wire logic tx_req_i,
	input wire logic tx_done_i,
	output logic tx_start_o,
	// receive shifter and fifo
	input wire logic rx_req_i,
	input wire logic rx_done_i,
	output logic rx_start_o,
	input wire logic [3:0] rx_fifo_level_i
);

	import flow_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_s1_reg, rst_s2_reg;
	logic rst_n;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign rst_n = rst_s2_reg;

	////////////////////////////////////////////////////////////////////////
	// clear-to-send input
	logic cts_level;
	logic cts_asserted;

	pin_sync #(
		.rst_val(cts_level_rst)
	) u_cts_sync (
		.clk_i(clk_i),
		.nrst_i(rst_n),
		.pin_i(clear_to_send_pin_i),
		.level_o(cts_level)
	);

	////////////////////////////////////////////////////////////////////////
	// registers
	extra_control_s ctrl_reg, ctrl_next;
	logic [7:0] scratch_reg, scratch_next;
	logic mcr_rts_reg, mcr_rts_next;
	logic rts_pin_reg, rts_pin_next;
	logic tx_idle, rx_idle;

	// cts polarity
	assign cts_asserted = ctrl_reg.cts_low_assert ? !cts_level : cts_level;

	////////////////////////////////////////////////////////////////////////
	// direction gates
	logic tx_allow, rx_allow;

	// tx flow only looks at cts; rx start only at its own enable
	assign tx_allow = ctrl_reg.tx_enable && (!ctrl_reg.tx_auto_flow || cts_asserted);
	assign rx_allow = ctrl_reg.rx_enable;

	symbol_gate u_tx_gate (
		.clk_i(clk_i),
		.nrst_i(rst_n),
		.allow_i(tx_allow),
		.req_i(tx_req_i),
		.done_i(tx_done_i),
		.start_o(tx_start_o),
		.idle_o(tx_idle)
	);

	symbol_gate u_rx_gate (
		.clk_i(clk_i),
		.nrst_i(rst_n),
		.allow_i(rx_allow),
		.req_i(rx_req_i),
		.done_i(rx_done_i),
		.start_o(rx_start_o),
		.idle_o(rx_idle)
	);

	////////////////////////////////////////////////////////////////////////
	// request-to-send
	logic [4:0] free_slots;
	logic [3:0] threshold;
	logic rtr_asserted;

	// level above depth is treated as full
	assign free_slots = (5'(rx_fifo_level_i) >= 5'(rx_fifo_depth)) ? 5'h00 :
		5'(rx_fifo_depth) - 5'(rx_fifo_level_i);

	always_comb begin
		case (ctrl_reg.rts_level)
			2'h0: threshold = thr_code0;
			2'h1: threshold = thr_code1;
			2'h2: threshold = thr_code2;
			2'h3: threshold = thr_code3;
			default: threshold = thr_code0;
		endcase
	end

	// deassert at or below threshold, reassert above it
	assign rtr_asserted = free_slots > 5'(threshold);

	// registered straight from the fifo level: one cycle of latency, so the
	// one-slot setting still stops the peer before the fifo overflows
	always_comb begin
		if (ctrl_reg.rx_auto_flow) begin
			rts_pin_next = rtr_asserted ^ ctrl_reg.rts_low_assert;
		end else begin
			rts_pin_next = !mcr_rts_reg;
		end
	end

	// the pin comes from a flop so the threshold compare cannot glitch the
	// line while the fifo level moves
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rts_pin_reg <= !mcr_rts_rst;
		end else begin
			rts_pin_reg <= rts_pin_next;
		end
	end

	assign request_to_send_pin_o = rts_pin_reg;

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: writes land in the data phase; reads take one wait
	// state so a read right after a write sees the new value
	bus_state_e state_reg, state_next;
	bus_req_s req_reg, req_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] read_value;
	logic accept;
	logic write_strobe;
	logic read_strobe;

	// an address phase is only taken while hready is high, which keeps it
	// out of the first cycle of a read data phase
	assign accept = hsel_i && htrans_i[1] && hready_i;
	assign write_strobe = (state_reg == bus_write);
	assign read_strobe = (state_reg == bus_fetch);

	always_comb begin
		read_value = 32'h0000_0000;
		case (req_reg.addr)
			modem_control_off: read_value[mcr_rts_bit] = mcr_rts_reg;
			modem_status_off: read_value[msr_cts_bit] = !cts_level;
			scratch_byte_off: read_value[7:0] = scratch_reg;
			extra_control_off: read_value[7:0] = ctrl_reg;
			flow_status_off: begin
				read_value[fst_cts_line_bit] = cts_level;
				read_value[fst_rts_line_bit] = rts_pin_reg;
				read_value[fst_tx_idle_bit] = tx_idle;
				read_value[fst_rx_idle_bit] = rx_idle;
			end
			default: read_value = 32'h0000_0000;
		endcase
	end

	// address and data phase sequencing; hsize is not decoded, every access
	// is taken as a whole word
	always_comb begin
		state_next = state_reg;
		req_next = req_reg;
		case (state_reg)
			bus_fetch: begin
				// hready is low here, so no address phase can be taken
				state_next = bus_read;
			end
			bus_idle, bus_write, bus_read: begin
				// a write data phase or the last read cycle may carry the next address
				if (accept) begin
					req_next.write = hwrite_i;
					req_next.addr = {haddr_i[7:2], 2'b00};
					state_next = hwrite_i ? bus_write : bus_fetch;
				end else begin
					state_next = bus_idle;
				end
			end
			default: begin
				state_next = bus_idle;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= bus_idle;
			req_reg <= '0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file: only the low byte of hwdata is kept, so software may
	// write any word without touching reserved bits
	always_comb begin
		ctrl_next = ctrl_reg;
		scratch_next = scratch_reg;
		mcr_rts_next = mcr_rts_reg;
		if (write_strobe) begin
			case (req_reg.addr)
				modem_control_off: mcr_rts_next = hwdata_i[mcr_rts_bit];
				scratch_byte_off: scratch_next = hwdata_i[7:0];
				extra_control_off: ctrl_next = hwdata_i[7:0];
				default: ctrl_next = ctrl_reg;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= extra_control_rst;
			scratch_reg <= scratch_rst;
			mcr_rts_reg <= mcr_rts_rst;
		end else begin
			ctrl_reg <= ctrl_next;
			scratch_reg <= scratch_next;
			mcr_rts_reg <= mcr_rts_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data register: loaded in the wait state and held until the next
	// read, so hrdata never changes under a slow master
	always_comb begin
		rdata_next = rdata_reg;
		if (read_strobe) begin
			rdata_next = read_value;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign hreadyout_o = (state_reg != bus_fetch);
	assign hresp_o = 1'b0;
	assign hrdata_o = rdata_reg;

endmodule

// ---- uart_modem_flow_monitor.sv ----
/*
  concurrent checks on the ports of uart_modem_flow.
  assumes hready_i is fed from hreadyout_o and the shifters hold a symbol 10 cycles.
*/
module uart_modem_flow_monitor #(
	parameter int rx_fifo_depth = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// bus
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// flow
	input wire logic request_to_send_pin_o,
	input wire logic [3:0] rx_fifo_level_i,
	input wire logic tx_req_i,
	input wire logic tx_done_i,
	input wire logic tx_start_o,
	input wire logic rx_req_i,
	input wire logic rx_start_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic wr_dp;
	logic take;
	assign take = hsel_i && htrans_i[1] && hready_i;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) wr_dp <= 1'h0;
		else wr_dp <= take && hwrite_i;
	end
	////////////////////////////////////////////////////////////////////////
	a_read_one_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write data phase stalled");
	a_resp_always_okay: assert property (hresp_o == 1'h0)
		else $error("response not okay");
	// rts may only move after a control write or a fifo level change
	a_rts_has_cause: assert property ($changed(request_to_send_pin_o) |-> $past(wr_dp) ||
		$past(wr_dp, 2) || $past(rx_fifo_level_i) != $past(rx_fifo_level_i, 2))
		else $error("rts moved without cause");
	a_tx_start_req: assert property (tx_start_o |-> tx_req_i)
		else $error("tx start without request");
	a_tx_busy_hold: assert property (tx_start_o |=> !tx_start_o [*8])
		else $error("tx restarted in flight");
	a_tx_done_gap: assert property (tx_done_i |-> !tx_start_o)
		else $error("tx start on done cycle");
	a_rx_start_req: assert property (rx_start_o |-> rx_req_i)
		else $error("rx start without request");
	a_rx_busy_hold: assert property (rx_start_o |=> !rx_start_o [*8])
		else $error("rx restarted in flight");
endmodule
bind uart_modem_flow uart_modem_flow_monitor #(.rx_fifo_depth(rx_fifo_depth)) mon (
	.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.request_to_send_pin_o(request_to_send_pin_o), .rx_fifo_level_i(rx_fifo_level_i),
	.tx_req_i(tx_req_i), .tx_done_i(tx_done_i), .tx_start_o(tx_start_o),
	.rx_req_i(rx_req_i), .rx_start_o(rx_start_o));

// ---- serial_peer.sv ----
/*
  far side: handshake level on cts and two symbol shifters (0 tx, 1 rx).
  assumes go_i pulses queue one symbol; a request stays up until granted.
*/
module serial_peer (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// bench control
	input wire logic cts_lvl_i,
	input wire logic [1:0] go_i,
	// design side
	input wire logic [1:0] start_i,
	output logic cts_o,
	output logic [1:0] req_o,
	output logic [1:0] done_o,
	output logic [1:0][7:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0][3:0] busy_reg;
	assign cts_o = cts_lvl_i;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_o <= '0;
			done_o <= '0;
			busy_reg <= '0;
			cnt_o <= '0;
		end else for (int i = 0; i < 2; i++) begin
			done_o[i] <= busy_reg[i] == 4'h1;
			if (start_i[i]) begin
				req_o[i] <= 1'h0;
				busy_reg[i] <= 4'ha;
				cnt_o[i] <= cnt_o[i] + 8'h1;
			end else begin
				// a refused request is kept, never dropped
				if (go_i[i]) req_o[i] <= 1'h1;
				if (busy_reg[i] != 4'h0) busy_reg[i] <= busy_reg[i] - 4'h1;
			end
		end
	end
endmodule

// ---- uart_modem_flow_tb.sv ----
/*
  self-checking bench for uart_modem_flow with serial_peer on the far side.
  assumes flow_pkg and the monitor bind are compiled first.
*/
module uart_modem_flow_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import flow_pkg::*;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_s;
	logic clk_i, nrst_i, hsel, hwrite, hready, hresp, cts, rts, cts_lvl;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, req, done, start, go;
	logic [1:0][7:0] cnt;
	logic [3:0] lvl;
	logic [3:0] thr [4] = '{4'h3, 4'h2, 4'h1, 4'h4};
	int err_count, num_checks;
	row_s rows [9] = '{'{scratch_byte_off, 32'ha5, 32'ha5}, '{scratch_byte_off, 32'hffffff5a, 32'h5a},
		'{extra_control_off, 32'hf3, 32'hf3}, '{modem_control_off, 32'hff, 32'h02},
		'{modem_status_off, 32'h00, 32'h10}, '{8'h14, 32'hff, 32'h00},
		'{modem_control_off, 32'h00, 32'h00}, '{extra_control_off, 32'hffffff03, 32'h03},
		'{flow_status_off, 32'hff, 32'h0e}};
	uart_modem_flow dut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.clear_to_send_pin_i(cts), .request_to_send_pin_o(rts), .tx_req_i(req[0]),
		.tx_done_i(done[0]), .tx_start_o(start[0]), .rx_req_i(req[1]), .rx_done_i(done[1]),
		.rx_start_o(start[1]), .rx_fifo_level_i(lvl));
	serial_peer peer (.clk_i(clk_i), .nrst_i(nrst_i), .cts_lvl_i(cts_lvl), .go_i(go),
		.start_i(start), .cts_o(cts), .req_o(req), .done_o(done), .cnt_o(cnt));
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_i); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'h1);
		r = hrdata;
	endtask
	task rst;
		@(posedge clk_i) nrst_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
	endtask
	task pend(input int d);
		@(posedge clk_i) go[d] <= 1'h1;
		@(posedge clk_i) go[d] <= 1'h0;
	endtask
	task starts(input int d, input logic [7:0] n);
		repeat (16) @(posedge clk_i);
		check({24'h0, cnt[d]}, {24'h0, n});
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200us;
		err_count++;
		results();
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, go, cts_lvl, lvl} = '0;
		nrst_i = 1'h0;
		rst();
		foreach (rows[i]) begin
			bus(1'h1, rows[i].a, rows[i].d);
			bus(1'h0, rows[i].a, 32'h0);
			check(r, rows[i].q);
		end
		$display("register rows done");
		bus(1'h0, scratch_byte_off, 32'h0);
		rst();
		bus(1'h0, extra_control_off, 32'h0);
		check(r, 32'h03);
		bus(1'h0, scratch_byte_off, 32'h0);
		check(r, 32'h00);
		check({31'h0, rts}, 32'h1);
		cts_lvl <= 1'h1;
		repeat (6) @(posedge clk_i);
		bus(1'h0, modem_status_off, 32'h0);
		check(r, 32'h00);
		$display("reset test done");
		for (int c = 0; c < 4; c++) begin
			bus(1'h1, extra_control_off, {26'h0, c[1:0], 4'h7});
			lvl <= 4'h8 - thr[c];
			repeat (3) @(posedge clk_i);
			check({31'h0, rts}, 32'h0);
			lvl <= 4'h7 - thr[c];
			repeat (3) @(posedge clk_i);
			check({31'h0, rts}, 32'h1);
		end
		bus(1'h1, extra_control_off, 32'h47);
		lvl <= 4'h0;
		repeat (3) @(posedge clk_i);
		check({31'h0, rts}, 32'h0);
		lvl <= 4'h8;
		repeat (3) @(posedge clk_i);
		check({31'h0, rts}, 32'h1);
		bus(1'h1, modem_control_off, 32'h02);
		bus(1'h1, extra_control_off, 32'h0b);
		repeat (3) @(posedge clk_i);
		check({31'h0, rts}, 32'h0);
		$display("rts test done");
		pend(0);
		starts(0, 8'h1);
		cts_lvl <= 1'h0;
		repeat (6) @(posedge clk_i);
		pend(0);
		starts(0, 8'h1);
		pend(1);
		starts(1, 8'h1);
		bus(1'h1, extra_control_off, 32'h8b);
		starts(0, 8'h2);
		bus(1'h1, extra_control_off, 32'h01);
		pend(0);
		starts(0, 8'h2);
		bus(1'h1, extra_control_off, 32'h03);
		starts(0, 8'h3);
		bus(1'h1, extra_control_off, 32'h02);
		pend(1);
		starts(1, 8'h1);
		bus(1'h1, extra_control_off, 32'h03);
		starts(1, 8'h2);
		cts_lvl <= 1'h1;
		bus(1'h1, extra_control_off, 32'h0b);
		repeat (6) @(posedge clk_i);
		pend(0);
		cts_lvl <= 1'h0;
		pend(0);
		starts(0, 8'h4);
		cts_lvl <= 1'h1;
		starts(0, 8'h5);
		bus(1'h1, extra_control_off, 32'h07);
		$display("flow test done");
		results();
	end
endmodule
